// [hw/pack_presence_safety_monitor.v]
// Pack presence sampling, sleep entry, fuse, fault latch, thermistor and LED control
// Behaviour
// - Active pull-up pulse 5 ms every 250 ms.
// - Sample presence pin just before pulse ends.
// - Active presence from last four samples.
// - Sleep pulses once per configurable period.
// - Pull-down on whenever no pulse runs.
// - Both bus lines low: calibrate, then sleep.
// - Fuse command drives fuse output high.
// - Fuse pin read reports secondary protector state.
// - Safety thermistor trip sets permanent fault.
// - Permanent fault clears only on power-on reset.
// - Four thermistor pull-ups, each independently enabled.
// - Precharge gate output drives limited charge path.
// - Three LED sinks; display request shows LEDs.
`timescale 1ns/1ps
`include "pack_monitor_consts.vh"

module pack_presence_safety_monitor (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  input  wire        i_system_present_n,
  input  wire [23:0] i_sleep_period,
  input  wire        i_smb_clk,
  input  wire        i_smb_data,
  input  wire        i_cal_done,
  input  wire        i_wake,
  input  wire        i_fuse_cmd,
  input  wire        i_fuse_pin,
  input  wire        i_safety_thermistor_enable,
  input  wire        i_ptc_trip,
  input  wire        i_fault_clear,
  input  wire [3:0]  i_therm_pullup_en,
  input  wire        i_precharge_req,
  input  wire        i_display_request_n,
  input  wire [2:0]  i_led_pattern,
  output reg         o_presence_pullup_on,
  output reg         o_presence_pulldown_on,
  output reg         o_present,
  output reg         o_sleep,
  output reg         o_cal_start,
  output reg         o_frontend_fuse_out,
  output reg         o_protector_tripped,
  output reg         o_ptc_fault,
  output reg  [3:0]  o_therm_pullup,
  output reg         o_precharge_gate_drive,
  output reg  [2:0]  o_led_sink_out
);

  // ---------------------------------------------------------------
  // Mode state machine
  // ---------------------------------------------------------------
  localparam [2:0] ST_ACTIVE = 3'b001;
  localparam [2:0] ST_CAL    = 3'b010;
  localparam [2:0] ST_SLEEP  = 3'b100;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [3:0]  samples_q;
  reg  [23:0] period_sel;
  wire        pulse;
  wire        sample;
  wire        bus_low = !i_smb_clk && !i_smb_data;

  function [2:0] count_low;
    input [3:0] s;
    begin
      count_low = {2'b00, s[0]} + {2'b00, s[1]} + {2'b00, s[2]} + {2'b00, s[3]};
    end
  endfunction

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_ACTIVE: if (bus_low) state_d = ST_CAL;
      ST_CAL:    if (i_cal_done) state_d = ST_SLEEP;
      ST_SLEEP:  if (i_wake && !bus_low) state_d = ST_ACTIVE;
      default:   state_d = ST_ACTIVE;
    endcase
  end

  always @* begin
    if (state_q == ST_SLEEP)
      period_sel = i_sleep_period;
    else
      period_sel = `ACTIVE_PERIOD_24;
  end

  // ---------------------------------------------------------------
  // Pulse timer
  // ---------------------------------------------------------------
  presence_pulser #(
    .WIDTH_CYC (`WIDTH_CYCLES_24)
  ) u_pulser (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_ce     (i_ce),
    .i_period (period_sel),
    .o_pulse  (pulse),
    .o_sample (sample)
  );

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q                <= ST_ACTIVE;
      samples_q              <= 4'h0;
      o_presence_pullup_on   <= 1'b0;
      o_presence_pulldown_on <= 1'b1;
      o_present              <= 1'b0;
      o_sleep                <= 1'b0;
      o_cal_start            <= 1'b0;
      o_frontend_fuse_out    <= 1'b0;
      o_protector_tripped    <= 1'b0;
      o_ptc_fault            <= 1'b0;
      o_therm_pullup         <= 4'h0;
      o_precharge_gate_drive <= 1'b0;
      o_led_sink_out         <= 3'h0;
    end else if (i_ce) begin
      state_q                <= state_d;
      o_sleep                <= (state_d == ST_SLEEP);
      o_cal_start            <= (state_q == ST_ACTIVE) && (state_d == ST_CAL);
      o_presence_pullup_on   <= pulse;
      o_presence_pulldown_on <= !pulse;
      if (sample) begin
        samples_q <= {samples_q[2:0], !i_system_present_n};
        if (state_q == ST_SLEEP)
          o_present <= !i_system_present_n;
        else
          o_present <= count_low({samples_q[2:0], !i_system_present_n})
                       >= `PRESENT_MIN_LOW;
      end
      if (i_fuse_cmd)
        o_frontend_fuse_out <= 1'b1;
      o_protector_tripped    <= i_fuse_pin;
      // Fault ignores i_fault_clear; only reset clears it
      if (i_safety_thermistor_enable && i_ptc_trip)
        o_ptc_fault <= 1'b1;
      o_therm_pullup         <= i_therm_pullup_en;
      o_precharge_gate_drive <= i_precharge_req;
      o_led_sink_out         <= i_display_request_n ? 3'h0 : i_led_pattern;
    end
  end

endmodule // pack_presence_safety_monitor

// [hw/pack_monitor_consts.vh]
// Constants for the pack presence and safety monitor
`ifndef PACK_MONITOR_CONSTS_VH
`define PACK_MONITOR_CONSTS_VH

`define CLK_FREQ_HZ       40000000
`define PULSE_PERIOD_MS   250
`define PULSE_WIDTH_MS    5
`define PERIOD_CYCLES     ((`CLK_FREQ_HZ / 1000) * `PULSE_PERIOD_MS)
`define WIDTH_CYCLES      ((`CLK_FREQ_HZ / 1000) * `PULSE_WIDTH_MS)
`define CNT_W             24
`define SAMPLE_DEPTH      4
`define PRESENT_MIN_LOW   3
`define SLEEP_PERIOD_RST  24'h989680
`define ACTIVE_PERIOD_24  24'h989680
`define WIDTH_CYCLES_24   24'h030d40
`define LED_SINKS         3
`define THERM_INPUTS      4

`endif

// [hw/presence_pulser.v]
// Presence pin pulse timer: one test pulse per period, sample strobe at its end
`timescale 1ns/1ps
`include "pack_monitor_consts.vh"

module presence_pulser #(
  parameter [23:0] WIDTH_CYC = `WIDTH_CYCLES_24
) (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  input  wire [23:0] i_period,
  output reg         o_pulse,
  output reg         o_sample
);

  reg [23:0] cnt_q;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q    <= 24'h000000;
      o_pulse  <= 1'b0;
      o_sample <= 1'b0;
    end else if (i_ce) begin
      o_sample <= 1'b0;
      if (cnt_q >= i_period - 24'h000001) begin
        cnt_q   <= 24'h000000;
        o_pulse <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 24'h000001;
        if (cnt_q == WIDTH_CYC - 24'h000002)
          o_sample <= 1'b1;
        if (cnt_q == WIDTH_CYC - 24'h000001)
          o_pulse <= 1'b0;
      end
    end
  end

endmodule // presence_pulser

// [verification/host_model.sv]
// Host side of the pack connector driving the presence pin
`timescale 1ns/1ps
module host_model (
  input  wire i_installed,
  input  wire i_pullup,
  output wire o_pin
);
  // A removed pack leaves the pin to the device's own source and sink
  assign o_pin = i_installed ? 1'b0 : i_pullup;
endmodule  // host_model

// [verification/pack_monitor_assertions.sv]
// Port checker for the pack presence and safety monitor
`timescale 1ns/1ps
module pack_monitor_chk (
  input wire       i_clk, i_rst_n, i_ce, i_smb_clk, i_smb_data, i_fuse_cmd, i_fuse_pin,
  input wire       i_safety_thermistor_enable, i_ptc_trip, i_precharge_req,
  input wire       i_display_request_n, o_presence_pullup_on, o_presence_pulldown_on,
  input wire       o_cal_start, o_frontend_fuse_out, o_protector_tripped, o_ptc_fault,
  input wire       o_precharge_gate_drive,
  input wire [3:0] i_therm_pullup_en, o_therm_pullup,
  input wire [2:0] i_led_pattern, o_led_sink_out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  pull_split_a: assert property (o_presence_pulldown_on != o_presence_pullup_on)
    else $error("pull-up and pull-down not complementary");
  fuse_set_a: assert property (i_ce && i_fuse_cmd |=> o_frontend_fuse_out [*3])
    else $error("fuse output not held high");
  prot_read_a: assert property (i_ce |=> o_protector_tripped == $past(i_fuse_pin))
    else $error("protector readback wrong");
  ptc_set_a: assert property (i_ce && i_ptc_trip && i_safety_thermistor_enable |=> o_ptc_fault)
    else $error("thermistor trip not latched");
  ptc_hold_a: assert property (o_ptc_fault |=> o_ptc_fault)
    else $error("permanent fault cleared");
  therm_pass_a: assert property (i_ce |=> o_therm_pullup == $past(i_therm_pullup_en))
    else $error("thermistor pull-up wrong");
  precharge_gate_drive_pass_a: assert property (i_ce |=> o_precharge_gate_drive == $past(i_precharge_req))
    else $error("precharge drive wrong");
  led_show_a: assert property (i_ce |=> o_led_sink_out ==
    ($past(i_display_request_n) ? 3'h0 : $past(i_led_pattern)))
    else $error("led sinks wrong");
  cal_cause_a: assert property ($rose(o_cal_start) |-> $past(!i_smb_clk && !i_smb_data))
    else $error("calibration without both bus lines low");
endmodule  // pack_monitor_chk
bind pack_presence_safety_monitor pack_monitor_chk u_chk (.*);

// [verification/tb.sv]
// Self-checking bench for the pack presence and safety monitor
`timescale 1ns/1ps
module tb;
  logic i_clk = 0, i_rst_n = 0, i_ce = 1, i_smb_clk = 1, i_smb_data = 1, i_cal_done = 0;
  logic i_wake = 0, i_fuse_cmd = 0, i_fuse_pin = 0, i_safety_thermistor_enable = 1;
  logic i_ptc_trip = 0, i_fault_clear = 0, i_precharge_req = 0, i_display_request_n = 1;
  logic installed = 1;
  logic [23:0] i_sleep_period = 24'h030d41;
  logic [3:0] i_therm_pullup_en = 4'h0, held;
  logic [2:0] i_led_pattern = 3'h0;
  wire i_system_present_n, o_presence_pullup_on, o_presence_pulldown_on, o_present, o_sleep;
  wire o_cal_start, o_frontend_fuse_out, o_protector_tripped, o_ptc_fault, o_precharge_gate_drive;
  wire [3:0] o_therm_pullup;
  wire [2:0] o_led_sink_out;
  int error_cnt = 0, comparisons = 0, seed;
  pack_presence_safety_monitor u_dut (.*);
  host_model u_host (.i_installed(installed), .i_pullup(o_presence_pullup_on),
                     .o_pin(i_system_present_n));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function logic [2:0] led_exp(input logic req_n, input logic [2:0] p);
    return req_n ? 3'h0 : p;
  endfunction
  initial forever #12.5 i_clk = ~i_clk;
  initial begin #50000; error_cnt++; summarize; end
  initial begin
    seed = $urandom(60);
    repeat (16) @(negedge i_clk);
    chk({o_presence_pullup_on, o_presence_pulldown_on, o_frontend_fuse_out, o_ptc_fault}, 8'h4);
    i_rst_n = 1;
    repeat (200) begin
      @(negedge i_clk);
      {i_therm_pullup_en, i_led_pattern, i_display_request_n, i_precharge_req, i_fuse_pin} =
        10'($urandom);
      @(negedge i_clk);
      chk(o_therm_pullup, i_therm_pullup_en);
      chk(o_led_sink_out, led_exp(i_display_request_n, i_led_pattern));
      chk({o_precharge_gate_drive, o_protector_tripped}, {i_precharge_req, i_fuse_pin});
    end
    i_fuse_cmd = 1;
    @(negedge i_clk);
    i_fuse_cmd = 0;
    i_ptc_trip = 1;
    @(negedge i_clk);
    i_ptc_trip = 0;
    i_fault_clear = 1;
    repeat (3) @(negedge i_clk);
    chk({o_frontend_fuse_out, o_ptc_fault}, 8'h3);
    {i_smb_clk, i_smb_data} = 2'h0;
    for (int i = 0; i < 20 && o_cal_start !== 1'b1; i++) @(negedge i_clk);
    chk(o_cal_start, 8'h1);
    i_cal_done = 1;
    repeat (3) @(negedge i_clk);
    chk(o_sleep, 8'h1);
    held = o_therm_pullup;
    i_ce = 0;
    i_therm_pullup_en = ~held;
    repeat (2) @(negedge i_clk);
    chk(o_therm_pullup, held);
    i_ce = 1;
    {i_smb_clk, i_smb_data} = 2'h3;
    i_wake = 1;
    repeat (2) @(negedge i_clk);
    chk(o_sleep, 8'h0);
    i_wake = 0;
    i_rst_n = 0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1;
    @(negedge i_clk);
    chk({o_frontend_fuse_out, o_ptc_fault, o_sleep}, 8'h0);
    chk({o_present, o_presence_pullup_on, o_presence_pulldown_on}, 8'h1);
    summarize;
  end
endmodule  // tb
